//--- bmc_map.vh
// register address, bit positions, reset value and timing of the basic mode control register
`ifndef BMC_MAP_VH
`define BMC_MAP_VH
`define BMC_ADDR          5'h00
`define BMC_RESET_VALUE   16'h3100
`define BMC_BIT_RESET     15
`define BMC_BIT_LOOPBACK  14
`define BMC_BIT_SPEED     13
`define BMC_BIT_AN_EN     12
`define BMC_BIT_PWR_DOWN  11
`define BMC_BIT_ISOLATE   10
`define BMC_BIT_AN_RST    9
`define BMC_BIT_DUPLEX    8
`define BMC_BIT_COL_TEST  7
`define BMC_RSVD_MSB      6
`define BMC_CLK_MHZ       125
`define BMC_SWRST_NS      800
`define BMC_LOOP_DEAD_MS  720
`endif

//--- mii_gate.v
// gates the mii datapath for isolate, power down and collision test
module mii_gate
(
    input  wire       isolate,     // float mii outputs, ignore tx inputs
    input  wire       power_down,  // hold outputs quiet
    input  wire       col_test,    // loop tx_en onto col
    input  wire [3:0] core_txd,    // synchronised transmit nibble
    input  wire       core_tx_en,  // synchronised transmit enable
    input  wire       core_tx_er,  // synchronised transmit error
    input  wire       core_tx_clk, // tx clock from core
    input  wire       core_rx_clk, // rx clock from core
    input  wire [3:0] core_rxd,    // receive nibble from core
    input  wire       core_rx_dv,  // receive data valid from core
    input  wire       core_rx_er,  // receive error from core
    input  wire       core_col,    // collision from core
    input  wire       core_crs,    // carrier sense from core
    output wire [3:0] phy_txd,     // transmit nibble to core
    output wire       phy_tx_en,   // transmit enable to core
    output wire       phy_tx_er,   // transmit error to core
    output wire       tx_clk,      // mii tx clock
    output wire       rx_clk,      // mii rx clock
    output wire [3:0] rxd,         // mii rx nibble
    output wire       rx_dv,       // mii rx valid
    output wire       rx_er,       // mii rx error
    output wire       col,         // mii collision
    output wire       crs,         // mii carrier sense
    output wire       mii_oe       // high while mii outputs are driven
);
    wire tx_ok;
    wire quiet;

    assign tx_ok     = ~isolate & ~power_down;
    assign phy_txd   = tx_ok ? core_txd : 4'h0;
    assign phy_tx_en = tx_ok & core_tx_en;
    assign phy_tx_er = tx_ok & core_tx_er;
    // power down holds everything low rather than floating, no edges once down
    assign quiet     = power_down | isolate;
    assign tx_clk    = ~quiet & core_tx_clk;
    assign rx_clk    = ~quiet & core_rx_clk;
    assign rxd       = quiet ? 4'h0 : core_rxd;
    assign rx_dv     = ~quiet & core_rx_dv;
    assign rx_er     = ~quiet & core_rx_er;
    assign col       = ~quiet & (core_col | (col_test & core_tx_en));
    assign crs       = ~quiet & core_crs;
    assign mii_oe    = ~isolate;
endmodule

//--- phy_basic_mode_control.v
// basic mode control register of the phy with its control effects
//
// Functional notes
// - loopback defaults zero; set enables loopback, 100M may lose lock 720ms
// - speed defaults one: one is 100M, zero is 10M
// - with autoneg enabled speed reads the negotiated speed
// - autoneg enable defaults one; speed and duplex then show results
// - power down defaults zero; management keeps working while down
// - no spurious mii output transitions entering or during power down; entry drops high outputs low at once
// - isolate ignores tx data, tx_en and tx_er
// - isolate floats all mii outputs
// - isolated device still answers management
// - restart bit restarts autoneg, self clears once started
// - restart has no effect with autoneg disabled
// - clearing restart never disturbs a running negotiation
// - duplex defaults full; manual choice only with autoneg disabled
// - with autoneg enabled duplex reads negotiated duplex
// - collision test asserts col whenever tx_en is asserted
// - bits six to zero read zero, writes ignored
`include "bmc_map.vh"
module phy_basic_mode_control
#(
    parameter SWRST_CYCLES = (`BMC_SWRST_NS * `BMC_CLK_MHZ + 999) / 1000
)
(
    input  wire        core_clk,     // 125 mhz clock
    input  wire        rst_b,        // async chip reset, active low
    input  wire        mgmt_wr,      // management write strobe, one cycle
    input  wire        mgmt_rd,      // management read strobe, one cycle
    input  wire [4:0]  mgmt_addr,    // management register address
    input  wire [15:0] mgmt_wdata,   // management write data
    output reg  [15:0] mgmt_rdata,   // read data, valid cycle after mgmt_rd
    output wire        mgmt_hit,     // address selects this register
    input  wire        an_started,   // autoneg engine accepted a restart
    input  wire        an_speed,     // negotiated speed, 1 = 100M
    input  wire        an_duplex,    // negotiated duplex, 1 = full
    output reg         an_restart,   // one-cycle restart pulse to engine
    output wire        an_enable,    // autoneg enable level
    output wire        speed_100,    // effective speed
    output wire        full_duplex,  // effective duplex
    output wire        loopback,     // loopback enable
    output wire        power_down,   // power down level
    output wire        soft_reset,   // registers held at defaults
    input  wire [3:0]  txd_pin,      // mii transmit nibble
    input  wire        tx_en_pin,    // mii transmit enable
    input  wire        tx_er_pin,    // mii transmit error
    input  wire        core_tx_clk,  // tx clock from core
    input  wire        core_rx_clk,  // rx clock from core
    input  wire [3:0]  core_rxd,     // rx nibble from core
    input  wire        core_rx_dv,   // rx valid from core
    input  wire        core_rx_er,   // rx error from core
    input  wire        core_col,     // collision from core
    input  wire        core_crs,     // carrier sense from core
    output wire [3:0]  phy_txd,      // gated transmit nibble
    output wire        phy_tx_en,    // gated transmit enable
    output wire        phy_tx_er,    // gated transmit error
    output wire        tx_clk,       // mii tx clock
    output wire        rx_clk,       // mii rx clock
    output wire [3:0]  rxd,          // mii rx nibble
    output wire        rx_dv,        // mii rx valid
    output wire        rx_er,        // mii rx error
    output wire        col,          // mii collision
    output wire        crs,          // mii carrier sense
    output wire        mii_oe        // high while mii outputs driven
);
    reg        loop_r;
    reg        speed_r;
    reg        an_en_r;
    reg        pd_r;
    reg        iso_r;
    reg        duplex_r;
    reg        colt_r;
    reg        an_rst_pend;
    reg [15:0] swrst_cnt;
    reg [5:0]  tx_s1;
    reg [5:0]  tx_s2;
    wire       wr_hit;
    wire       swrst_busy;
    wire [15:0] reg_view;

    assign mgmt_hit   = (mgmt_addr == `BMC_ADDR);
    assign wr_hit     = mgmt_wr & mgmt_hit;
    assign swrst_busy = (swrst_cnt != 16'h0000);
    assign soft_reset = swrst_busy;

    // software reset runs a short counter; defaults are loaded at its start
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            swrst_cnt <= 16'h0000;
        else if (wr_hit && mgmt_wdata[`BMC_BIT_RESET])
            swrst_cnt <= SWRST_CYCLES[15:0];
        else if (swrst_busy)
            swrst_cnt <= swrst_cnt - 16'h0001;
    end

    // writes are still accepted in power down and isolate
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_r   <= 1'b0;
            speed_r  <= 1'b1;
            an_en_r  <= 1'b1;
            pd_r     <= 1'b0;
            iso_r    <= 1'b0;
            duplex_r <= 1'b1;
            colt_r   <= 1'b0;
        end
        else if (swrst_busy || (wr_hit && mgmt_wdata[`BMC_BIT_RESET]))
        begin
            loop_r   <= 1'b0;
            speed_r  <= 1'b1;
            an_en_r  <= 1'b1;
            pd_r     <= 1'b0;
            iso_r    <= 1'b0;
            duplex_r <= 1'b1;
            colt_r   <= 1'b0;
        end
        else if (wr_hit)
        begin
            loop_r   <= mgmt_wdata[`BMC_BIT_LOOPBACK];
            speed_r  <= mgmt_wdata[`BMC_BIT_SPEED];
            an_en_r  <= mgmt_wdata[`BMC_BIT_AN_EN];
            pd_r     <= mgmt_wdata[`BMC_BIT_PWR_DOWN];
            iso_r    <= mgmt_wdata[`BMC_BIT_ISOLATE];
            duplex_r <= mgmt_wdata[`BMC_BIT_DUPLEX];
            colt_r   <= mgmt_wdata[`BMC_BIT_COL_TEST];
        end
    end

    // restart pending until engine reports start, autoneg is turned off or soft reset runs; a zero restart bit never cancels it
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            an_rst_pend <= 1'b0;
            an_restart  <= 1'b0;
        end
        else if (swrst_busy)
        begin
            an_rst_pend <= 1'b0;
            an_restart  <= 1'b0;
        end
        else
        begin
            an_restart <= 1'b0;
            if (wr_hit && mgmt_wdata[`BMC_BIT_AN_RST] && an_en_r && !an_rst_pend)
            begin
                an_rst_pend <= 1'b1;
                an_restart  <= 1'b1;
            end
            else if (an_rst_pend && (an_started || !an_en_r))
                an_rst_pend <= 1'b0;
        end
    end

    assign an_enable   = an_en_r;
    assign speed_100   = an_en_r ? an_speed : speed_r;
    assign full_duplex = an_en_r ? an_duplex : duplex_r;
    assign loopback    = loop_r;
    assign power_down  = pd_r;

    assign reg_view = {swrst_busy, loop_r, speed_100, an_en_r, pd_r, iso_r,
                       an_rst_pend, full_duplex, colt_r,
                       {(`BMC_RSVD_MSB + 1){1'b0}}};

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            mgmt_rdata <= 16'h0000;
        else if (mgmt_rd)
            mgmt_rdata <= mgmt_hit ? reg_view : 16'h0000;
    end

    // mii tx inputs come from the mac's clock, two flops before use
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_s1 <= 6'h00;
            tx_s2 <= 6'h00;
        end
        else
        begin
            tx_s1 <= {tx_er_pin, tx_en_pin, txd_pin};
            tx_s2 <= tx_s1;
        end
    end

    mii_gate u_gate
    (
        .isolate     (iso_r),
        .power_down  (pd_r),
        .col_test    (colt_r),
        .core_txd    (tx_s2[3:0]),
        .core_tx_en  (tx_s2[4]),
        .core_tx_er  (tx_s2[5]),
        .core_tx_clk (core_tx_clk),
        .core_rx_clk (core_rx_clk),
        .core_rxd    (core_rxd),
        .core_rx_dv  (core_rx_dv),
        .core_rx_er  (core_rx_er),
        .core_col    (core_col),
        .core_crs    (core_crs),
        .phy_txd     (phy_txd),
        .phy_tx_en   (phy_tx_en),
        .phy_tx_er   (phy_tx_er),
        .tx_clk      (tx_clk),
        .rx_clk      (rx_clk),
        .rxd         (rxd),
        .rx_dv       (rx_dv),
        .rx_er       (rx_er),
        .col         (col),
        .crs         (crs),
        .mii_oe      (mii_oe)
    );
endmodule

//--- phy_bmc_sva.sv
// port-level assertions for the basic mode control register
module phy_bmc_sva #(parameter int SWRST_CYCLES = 100)
(
    input wire logic        core_clk, rst_b, mgmt_wr, mgmt_rd, mgmt_hit, an_speed, an_duplex,
    input wire logic        an_restart, an_enable, speed_100, full_duplex, soft_reset,
    input wire logic        power_down, loopback, phy_tx_en, tx_clk, rx_clk, rx_dv, rx_er,
    input wire logic        col, crs, mii_oe,
    input wire logic [4:0]  mgmt_addr,
    input wire logic [15:0] mgmt_wdata, mgmt_rdata,
    input wire logic [3:0]  rxd
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    int       rst_len;
    wire [9:0] mii_out = {tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs};
    always @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            rst_len <= 0;
        else
            rst_len <= soft_reset ? rst_len + 1 : 0;
    sequence s_rd_miss;
        mgmt_rd && !mgmt_hit;
    endsequence
    sequence s_pulse;
        an_restart ##1 !an_restart;
    endsequence
    property p_hit;    mgmt_hit == (mgmt_addr == 5'h00); endproperty
    property p_rsvd;   mgmt_rdata[6:0] == 7'h00; endproperty
    property p_rd_miss; s_rd_miss |=> mgmt_rdata == 16'h0000; endproperty
    property p_spd;    an_enable |-> speed_100 == an_speed; endproperty
    property p_dpx;    an_enable |-> full_duplex == an_duplex; endproperty
    property p_rst_src;
        an_restart |-> $past(mgmt_wr && mgmt_hit && mgmt_wdata[9] && an_enable);
    endproperty
    property p_pulse;  an_restart |-> s_pulse; endproperty
    property p_iso;    !mii_oe |-> mii_out == 10'h000 && !phy_tx_en; endproperty
    property p_pd;     power_down && $past(power_down) |-> $stable(mii_out); endproperty
    property p_swlen;  rst_len <= SWRST_CYCLES + 1; endproperty
    property p_swdef;  soft_reset |-> an_enable && !power_down && !loopback; endproperty
    a_hit: assert property (p_hit) else $error("hit wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_rd_miss: assert property (p_rd_miss) else $error("unmapped read nonzero");
    a_spd: assert property (p_spd) else $error("speed not negotiated");
    a_dpx: assert property (p_dpx) else $error("duplex not negotiated");
    a_rst_src: assert property (p_rst_src) else $error("restart without cause");
    a_pulse: assert property (p_pulse) else $error("restart pulse too long");
    a_iso: assert property (p_iso) else $error("isolated outputs active");
    a_pd: assert property (p_pd) else $error("output moved in power down");
    a_swlen: assert property (p_swlen) else $error("soft reset too long");
    a_swdef: assert property (p_swdef) else $error("defaults lost in reset");
endmodule
bind phy_basic_mode_control phy_bmc_sva #(.SWRST_CYCLES(SWRST_CYCLES)) u_bmc_sva (.*);

//--- an_engine_model.sv
// stand-in for the auto-negotiation engine behind the restart handshake
module an_engine_model #(parameter int LAG = 4)
(
    input  wire logic core_clk,   // clock
    input  wire logic rst_b,      // async reset, active low
    input  wire logic an_restart, // restart pulse
    output logic      an_started, // restart taken
    output int        starts      // restarts taken
);
    int left;
    always @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            left <= 0;
            an_started <= 1'b0;
            starts <= 0;
        end
        else
        begin
            an_started <= (left == 1);
            if (left == 1)
                starts <= starts + 1;
            // clearing writes never reach the engine, so a run goes on
            left <= an_restart ? LAG : (left > 0 ? left - 1 : 0);
        end
endmodule

//--- phy_basic_mode_control_test.sv
// register and mii gating tests for the basic mode control register
module phy_basic_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_b = 0, mgmt_wr = 0, mgmt_rd = 0, an_speed = 1, an_duplex = 1;
    logic tx_en_pin = 0, tx_er_pin = 0, core_tx_clk = 0, core_rx_clk = 0, core_rx_dv = 1;
    logic core_rx_er = 0, core_col = 0, core_crs = 1;
    logic [3:0] txd_pin = 4'h0, core_rxd = 4'h0;
    logic [4:0] mgmt_addr = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    wire [15:0] mgmt_rdata;
    wire [3:0] phy_txd, rxd;
    wire mgmt_hit, an_started, an_restart, an_enable, speed_100, full_duplex, loopback;
    wire power_down, soft_reset, phy_tx_en, phy_tx_er, tx_clk, rx_clk, rx_dv, rx_er, col, crs;
    wire mii_oe;
    int starts, err_total = 0, num_checks = 0;
    always #4 core_clk = ~core_clk;
    phy_basic_mode_control #(.SWRST_CYCLES(8)) dut (.*);
    an_engine_model #(.LAG(4)) partner (.core_clk, .rst_b, .an_restart, .an_started, .starts);
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] d);
        @(posedge core_clk);
        mgmt_wr <= 1'b1;
        mgmt_addr <= 5'h00;
        mgmt_wdata <= d;
        @(posedge core_clk);
        mgmt_wr <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a, logic [15:0] exp);
        @(posedge core_clk);
        mgmt_rd <= 1'b1;
        mgmt_addr <= a;
        @(posedge core_clk);
        mgmt_rd <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("rdata", exp, mgmt_rdata);
    endtask
    task automatic pause(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #(8 * 2000);
        err_total++;
        report_and_stop;
    end
    initial
    begin
        pause(3);
        rst_b <= 1'b1;
        rd(5'h00, 16'h3100);
        rd(5'h01, 16'h0000);
        an_speed <= 1'b0;
        an_duplex <= 1'b0;
        rd(5'h00, 16'h1000);
        $display("test defaults done");
        // reserved ones written on purpose, they must not stick
        wr(16'h007f);
        rd(5'h00, 16'h0000);
        wr(16'h0300);
        rd(5'h00, 16'h0100);
        chk("restarts", 16'h0000, starts[15:0]);
        $display("test manual mode done");
        // enable first: restart is only honoured with autoneg already on
        wr(16'h1000);
        wr(16'h1200);
        rd(5'h00, 16'h1200);
        pause(8);
        rd(5'h00, 16'h1000);
        wr(16'h1200);
        wr(16'h1000);
        pause(8);
        chk("restarts", 16'h0002, starts[15:0]);
        $display("test restart done");
        wr(16'h1080);
        tx_en_pin <= 1'b1;
        pause(4);
        chk("mii", 16'h000f, {12'h000, mii_oe, col, crs, phy_tx_en});
        wr(16'h1480);
        pause(4);
        chk("mii", 16'h0000, {12'h000, mii_oe, col, crs, phy_tx_en});
        rd(5'h00, 16'h1480);
        wr(16'h1800);
        rd(5'h00, 16'h1800);
        wr(16'h5000);
        pause(2);
        chk("modes", 16'h0002, {14'h0000, loopback, power_down});
        $display("test mii done");
        // negotiated results match defaults so the read shows 0x3100
        an_speed <= 1'b1;
        an_duplex <= 1'b1;
        wr(16'h8000);
        rd(5'h00, 16'hb100);
        pause(10);
        rd(5'h00, 16'h3100);
        $display("test soft reset done");
        report_and_stop;
    end
endmodule
